// ===== sim/motion_aux_command_decoder_test.sv
// testbench: command sequences through the register port
`timescale 1ns/1ps
`include "motion_aux_cfg.svh"

module motion_aux_command_decoder_test
  import motion_aux_pkg::*;
();
  logic clk_sys, srst, interp_event, interp_irq_out_n, interp_step, timer_up, prev;
  bus_req_type bus_req;
  logic [15:0] rdata, rv;
  axis_in_type axis_in;
  logic [3:0] sync_trigger, sync_fire, drive_go, deviation_clear_out, segment_pulse_out;
  logic [3:0] fire_acc, go_acc; // pulses gathered over a command gap
  int num_errors, n_tests, cyc, t0, tup_n, tup_cyc, tup_prev, step_n, dcc_n, seg_n;

  motion_aux_host_model host (.clk_sys(clk_sys), .bus_req(bus_req), .rdata(rdata));
  motion_aux_command_decoder uut (.clk_sys(clk_sys), .srst(srst), .bus_req(bus_req),
    .rdata(rdata), .axis_in(axis_in), .sync_trigger(sync_trigger),
    .interp_event(interp_event), .interp_irq_out_n(interp_irq_out_n),
    .interp_step(interp_step), .sync_fire(sync_fire), .drive_go(drive_go),
    .deviation_clear_out(deviation_clear_out), .segment_pulse_out(segment_pulse_out),
    .timer_up(timer_up));

  // ---------------------------------------------------------------
  // clock, pulse monitor and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // pulses are gathered here since a command gap would hide them
  always @(posedge clk_sys) begin
    if (!srst) begin
      fire_acc = fire_acc | sync_fire;
      go_acc = go_acc | drive_go;
      step_n += interp_step;
      dcc_n += deviation_clear_out[0];
      seg_n += segment_pulse_out[0];
      tup_n += timer_up;
      if (timer_up === 1'b1) begin
        tup_prev = tup_cyc;
        tup_cyc = cyc;
      end
    end
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    srst = 1'b1;
    axis_in = '0;
    sync_trigger = 4'h0;
    interp_event = 1'b0;
    {num_errors, n_tests, cyc, tup_n, tup_cyc, tup_prev, step_n, dcc_n, seg_n} = '0;
    {fire_acc, go_acc} = '0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk("dcc reset", {12'h000, deviation_clear_out}, 16'h000f);
    host.wr(`ADDR_CMD, 16'h007b);
    host.rd(`ADDR_PAGED, rv);
    chk("sets reset", rv & 16'h800f, 16'h8000);
    // sync sets: several at once, then activation
    host.wr(`ADDR_CMD, 16'h018f);
    host.wr(`ADDR_CMD, 16'h019a);
    host.rd(`ADDR_PAGED, rv);
    chk("sets", rv & 16'h000f, 16'h0005);
    fire_acc = 4'h0;
    host.wr(`ADDR_CMD, 16'h01af);
    chk("fire", {12'h000, fire_acc}, 16'h0005);
    fire_acc = 4'h0;
    host.wr(`ADDR_CMD, 16'h01a0);
    chk("fire none", {12'h000, fire_acc}, 16'h0000);
    sync_trigger <= 4'h3;
    tick(3);
    sync_trigger <= 4'h0;
    tick(2);
    chk("hw fire", {12'h000, fire_acc}, 16'h0001);
    // enable refused while an error stands
    axis_in.err_set <= 4'h1;
    axis_in.finish_set <= 4'h1;
    tick(1);
    axis_in.err_set <= 4'h0;
    axis_in.finish_set <= 4'h0;
    host.wr(`ADDR_OTHER, 16'h0080);
    host.wr(`ADDR_CMD, 16'h0182);
    host.rd(`ADDR_PAGED, rv);
    chk("enable refused", rv & 16'h000f, 16'h0005);
    host.rd(`ADDR_FAULT, rv);
    chk("fault", rv & 16'h00ff, 16'h0011);
    host.wr(`ADDR_CMD, 16'h0079);
    host.rd(`ADDR_MAIN, rv);
    chk("main err", rv & 16'h00f0, 16'h0000);
    host.rd(`ADDR_FAULT, rv);
    chk("fault clr", rv & 16'h00ff, 16'h0000);
    host.wr(`ADDR_CMD, 16'h0182);
    host.rd(`ADDR_PAGED, rv);
    chk("enable ok", rv & 16'h000f, 16'h0007);
    host.wr(`ADDR_CMD, 16'h007a);
    host.rd(`ADDR_PAGED, rv);
    chk("page0", rv & 16'h8000, 16'h0000);
    // interrupt clear and single step
    interp_event <= 1'b1;
    tick(1);
    interp_event <= 1'b0;
    tick(1);
    chk("irq", {15'h0000, interp_irq_out_n}, 16'h0000);
    step_n = 0;
    host.wr(`ADDR_CMD, 16'h006f);
    chk("irq clr", {15'h0000, interp_irq_out_n}, 16'h0001);
    chk("steps", 16'(step_n), 16'h0001);
    // speed step, interpolation kept off
    host.wr(`ADDR_STEP, 16'h0010);
    host.wr(`ADDR_DSPEED, 16'h0100);
    axis_in.driving <= 4'h1;
    axis_in.steady <= 4'h1;
    host.wr(`ADDR_CMD, 16'h0170);
    host.rd(`ADDR_CURSPD, rv);
    chk("speed up", rv, 16'h0110);
    host.rd(`ADDR_DSPEED, rv);
    chk("setting", rv, 16'h0100);
    axis_in.scurve <= 4'h1;
    axis_in.steady <= 4'h0;
    host.wr(`ADDR_CMD, 16'h0171);
    host.rd(`ADDR_CURSPD, rv);
    chk("ramp ignore", rv, 16'h0110);
    axis_in.steady <= 4'h1;
    host.wr(`ADDR_CMD, 16'h0171);
    host.rd(`ADDR_CURSPD, rv);
    chk("speed dn", rv, 16'h0100);
    // split pulse: stop inside a high phase keeps its width
    host.wr(`ADDR_SPLIT, 16'h0404);
    host.wr(`ADDR_CMD, 16'h007b);
    host.wr(`ADDR_CMD, 16'h0175);
    host.rd(`ADDR_PAGED, rv);
    chk("split on", rv & 16'h0040, 16'h0040);
    prev = 1'b1;
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (segment_pulse_out[0] === 1'b1 && prev === 1'b0) break;
      prev = segment_pulse_out[0];
    end
    seg_n = 0;
    host.wr(`ADDR_CMD, 16'h0176);
    tick(12);
    chk("split width", 16'(seg_n), 16'h0004);
    host.rd(`ADDR_PAGED, rv);
    chk("split off", rv & 16'h0040, 16'h0000);
    axis_in.driving <= 4'h0;
    // deviation clear: level 1, width 3
    host.wr(`ADDR_HOME2, 16'h0301);
    chk("dcc idle", {12'h000, deviation_clear_out}, 16'h0000);
    dcc_n = 0;
    host.wr(`ADDR_CMD, 16'h0172);
    tick(8);
    chk("dcc width", 16'(dcc_n), 16'h0003);
    // timer, single and repeating
    host.wr(`ADDR_TLIMIT, 16'h0005);
    tup_n = 0;
    t0 = cyc;
    host.wr(`ADDR_CMD, 16'h0073);
    tick(16);
    chk("timer once", 16'(tup_n), 16'h0001);
    chk("timer time", 16'(tup_cyc - t0), 16'h0007);
    host.wr(`ADDR_MODE3, 16'h4000);
    host.wr(`ADDR_CMD, 16'h0073);
    tick(16);
    chk("timer period", 16'(tup_cyc - tup_prev), 16'h0006);
    host.wr(`ADDR_CMD, 16'h0074);
    host.rd(`ADDR_TCOUNT, rv);
    chk("timer zero", rv, 16'h0000);
    tup_n = 0;
    tick(12);
    chk("timer halted", 16'(tup_n), 16'h0000);
    // held drive start on axes 0 and 1
    go_acc = 4'h0;
    host.wr(`ADDR_CMD, 16'h0377);
    host.wr(`ADDR_CMD, 16'h0350);
    chk("held", {12'h000, go_acc}, 16'h0000);
    host.wr(`ADDR_CMD, 16'h0078);
    chk("released", {12'h000, go_acc}, 16'h0003);
    host.rd(4'hf, rv);
    chk("unmapped", rv, 16'h0000);
    stop_test();
  end
endmodule // motion_aux_command_decoder_test

// ===== sim/motion_aux_host_model.sv
// host side model: register port master that spaces its command writes
`timescale 1ns/1ps
`include "motion_aux_cfg.svh"

module motion_aux_host_model
  import motion_aux_pkg::*;
(
  input wire logic clk_sys,
  output bus_req_type bus_req,
  input wire logic [15:0] rdata
);
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  initial bus_req = '0;

  // one write; a command write is followed by the acceptance gap
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    #1;
    bus_req.wr <= 1'b0;
    // idle cycle avoids two drives of the strobe in one step
    repeat ((a == `ADDR_CMD) ? `ACCEPT_CYC - 1 : 1) begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  // one read; data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    #1;
    bus_req.rd <= 1'b0;
    d = rdata;
    @(posedge clk_sys);
    #1;
  endtask
endmodule // motion_aux_host_model

// ===== sim/motion_aux_properties.sv
// checker: timing relations on the decoder ports
`timescale 1ns/1ps
`include "motion_aux_cfg.svh"

module motion_aux_checks
  import motion_aux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire bus_req_type bus_req,
  input wire logic [15:0] rdata,
  input wire axis_in_type axis_in,
  input wire logic [3:0] sync_trigger,
  input wire logic interp_event,
  input wire logic interp_irq_out_n,
  input wire logic interp_step,
  input wire logic [3:0] sync_fire,
  input wire logic [3:0] drive_go,
  input wire logic [3:0] deviation_clear_out,
  input wire logic [3:0] segment_pulse_out,
  input wire logic timer_up
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic cmd_w; // command write in this cycle
  logic [7:0] code; // command code field
  logic run_r; // timer started and not stopped
  logic pg_r; // last page chosen
  logic pg_ok_r; // a page was chosen since reset
  assign cmd_w = bus_req.wr && (bus_req.addr == `ADDR_CMD);
  assign code = bus_req.wdata[7:0];
  // timer run tracking
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      run_r <= 1'b0;
    end else if (cmd_w && (code == `CMD_TSTART || code == `CMD_TSTOP)) begin
      run_r <= (code == `CMD_TSTART);
    end
  end
  // page tracking, unknown until first page command
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pg_r <= 1'b0;
      pg_ok_r <= 1'b0;
    end else if (cmd_w && (code == `CMD_PAGE0 || code == `CMD_PAGE1)) begin
      pg_r <= (code == `CMD_PAGE1);
      pg_ok_r <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_irq_clear;
    cmd_w && code == `CMD_INTERP && !interp_event |=> interp_irq_out_n;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
  property p_irq_raise;
    interp_event |=> !interp_irq_out_n;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq not raised");
  property p_step;
    cmd_w && code == `CMD_INTERP |=> interp_step ##1 !interp_step;
  endproperty
  a_step: assert property (p_step) else $error("step pulse wrong");
  property p_step_cause;
    interp_step |-> $past(cmd_w && code == `CMD_INTERP);
  endproperty
  a_step_cause: assert property (p_step_cause) else $error("stray step");
  property p_empty_sel;
    cmd_w && code == 8'ha0 && sync_trigger == 4'h0 |=> sync_fire == 4'h0;
  endproperty
  a_empty_sel: assert property (p_empty_sel) else $error("empty select fired");
  property p_go_cause;
    drive_go != 4'h0 |-> $past(cmd_w);
  endproperty
  a_go_cause: assert property (p_go_cause) else $error("stray drive start");
  property p_timer_stop;
    timer_up |-> $past(run_r);
  endproperty
  a_timer_stop: assert property (p_timer_stop) else $error("timer up while stopped");
  property p_page_bit;
    bus_req.rd && bus_req.addr == `ADDR_PAGED && pg_ok_r |=> rdata[15] == pg_r;
  endproperty
  a_page_bit: assert property (p_page_bit) else $error("page bit wrong");
  property p_rdata_idle;
    !$past(bus_req.rd) |-> rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule // motion_aux_checks

bind motion_aux_command_decoder motion_aux_checks u_checks (.clk_sys(clk_sys), .srst(srst),
  .bus_req(bus_req), .rdata(rdata), .axis_in(axis_in), .sync_trigger(sync_trigger),
  .interp_event(interp_event), .interp_irq_out_n(interp_irq_out_n),
  .interp_step(interp_step), .sync_fire(sync_fire), .drive_go(drive_go),
  .deviation_clear_out(deviation_clear_out), .segment_pulse_out(segment_pulse_out),
  .timer_up(timer_up));

// ===== src/motion_aux_cfg.svh
// constants for the auxiliary command decoder of the four-axis motion controller
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`ifndef MOTION_AUX_CFG_SVH
`define MOTION_AUX_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ADDR_CMD 4'h0
`define ADDR_MODE3 4'h1
`define ADDR_OTHER 4'h2
`define ADDR_HOME2 4'h3
`define ADDR_TLIMIT 4'h4
`define ADDR_STEP 4'h5
`define ADDR_DSPEED 4'h6
`define ADDR_SPLIT 4'h7
`define ADDR_MAIN 4'h8
`define ADDR_FAULT 4'h9
`define ADDR_PAGED 4'ha
`define ADDR_TCOUNT 4'hb
`define ADDR_CURSPD 4'hc

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SPLIT_CFG_RESET 16'h0101
`define DCC_IDLE_RESET 4'hf

// ---------------------------------------------------------------
// command codes and fields
// ---------------------------------------------------------------
`define CMD_INTERP 8'h6f
`define CMD_SPD_UP 8'h70
`define CMD_SPD_DN 8'h71
`define CMD_DEVCLR 8'h72
`define CMD_TSTART 8'h73
`define CMD_TSTOP 8'h74
`define CMD_SPSTART 8'h75
`define CMD_SPSTOP 8'h76
`define CMD_HOLD 8'h77
`define CMD_RELEASE 8'h78
`define CMD_FCLEAR 8'h79
`define CMD_PAGE0 8'h7a
`define CMD_PAGE1 8'h7b
`define OP_ENABLE 4'h8
`define OP_DISABLE 4'h9
`define OP_ACTIVATE 4'ha
`define BIT_TREPEAT 14
`define BIT_FTRIG_DIS 7
`define BIT_STEADY 5
`define BIT_SPLIT 6
`define BIT_PAGE 15

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_MHZ 20
`define ACCEPT_NS 125
`define ACCEPT_CYC ((`ACCEPT_NS * `CLK_MHZ + 999) / 1000)

`endif

// ===== src/motion_aux_command_decoder.sv
// auxiliary command decoder: sync sets, speed step, timer, split, hold, fault clear
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "motion_aux_cfg.svh"

module motion_aux_command_decoder
  import motion_aux_pkg::*;
#(
  parameter int SPEED_W = 16, // drive speed width
  parameter int TIMER_W = 16  // timer width
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire bus_req_type bus_req,
  output logic [15:0] rdata,
  input wire axis_in_type axis_in,
  input wire logic [3:0] sync_trigger,
  input wire logic interp_event,
  output logic interp_irq_out_n,
  output logic interp_step,
  output logic [3:0] sync_fire,
  output logic [3:0] drive_go,
  output logic [3:0] deviation_clear_out,
  output logic [3:0] segment_pulse_out,
  output logic timer_up
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // counters and read mux assume at most a 16-bit data word
  if (SPEED_W < 2 || SPEED_W > 16) begin : g_bad_spd
    $error("SPEED_W out of range");
  end
  if (TIMER_W < 2 || TIMER_W > 16) begin : g_bad_tmr
    $error("TIMER_W out of range");
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // one write of the command register both carries the axes and runs the code
  logic cmd_wr; // command register written
  logic [3:0] cmd_axes; // axis assignment, bits 11..8
  logic [7:0] cmd_code; // command code
  logic [3:0] sel; // set selection
  // the axis field is ignored by the set operations
  assign cmd_wr = bus_req.wr && bus_req.addr == `ADDR_CMD;
  assign cmd_axes = bus_req.wdata[11:8];
  assign cmd_code = bus_req.wdata[7:0];
  assign sel = bus_req.wdata[3:0];

  // true only in the cycle that writes the given code
  function automatic logic is_cmd(input logic [7:0] c);
    is_cmd = cmd_wr && cmd_code == c;
  endfunction

  // ---------------------------------------------------------------
  // settings written by software
  // ---------------------------------------------------------------
  logic [15:0] mode3_r; // axis_mode_reg_3 image
  logic [15:0] other_r; // other settings, bit 7 fault_trigger_disable
  logic [15:0] home2_r; // bit 0 level, bits 15..8 width
  logic [TIMER_W-1:0] timer_limit_r; // timer limit
  logic [SPEED_W-1:0] speed_step_value_r; // speed step
  logic [SPEED_W-1:0] drive_speed_setting_r; // stored drive speed
  logic [15:0] split_cfg_r; // bits 7..0 high width, 15..8 low width
  // settings read back as written, limit, step and speed cut to TIMER_W or SPEED_W bits
  // plain setting registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode3_r <= 16'h0000;
      other_r <= 16'h0000;
      home2_r <= 16'h0000;
      timer_limit_r <= '0;
      speed_step_value_r <= '0;
      drive_speed_setting_r <= '0;
      split_cfg_r <= `SPLIT_CFG_RESET;
    end else if (bus_req.wr) begin
      // command and status offsets fall to the default arm
      unique case (bus_req.addr)
        `ADDR_MODE3: mode3_r <= bus_req.wdata;
        `ADDR_OTHER: other_r <= bus_req.wdata;
        `ADDR_HOME2: home2_r <= bus_req.wdata;
        `ADDR_TLIMIT: timer_limit_r <= bus_req.wdata[TIMER_W-1:0];
        `ADDR_STEP: speed_step_value_r <= bus_req.wdata[SPEED_W-1:0];
        `ADDR_DSPEED: drive_speed_setting_r <= bus_req.wdata[SPEED_W-1:0];
        `ADDR_SPLIT: split_cfg_r <= bus_req.wdata;
        default: ; // other addresses hold no setting
      endcase
    end
  end

  // ---------------------------------------------------------------
  // fault state
  // ---------------------------------------------------------------
  logic [3:0] axis_err_r; // per-axis error bits of main state
  logic [3:0] finish_r; // drive-finish bits
  // set wins over the clear command so no event is lost
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      axis_err_r <= 4'h0;
      finish_r <= 4'h0;
    end else if (is_cmd(`CMD_FCLEAR)) begin
      axis_err_r <= axis_in.err_set;
      finish_r <= axis_in.finish_set;
    end else begin
      // bits stay set until software clears them
      axis_err_r <= axis_err_r | axis_in.err_set;
      finish_r <= finish_r | axis_in.finish_set;
    end
  end

  // ---------------------------------------------------------------
  // synchronous action sets
  // ---------------------------------------------------------------
  logic [3:0] sync_en_r; // enable flags, shown on page 1
  logic en_block; // enable refused while errors stand and fault_trigger_disable is set
  assign en_block = other_r[`BIT_FTRIG_DIS] && (|axis_err_r);
  // one write updates every selected set together; empty select is a no-op
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_en_r <= 4'h0;
    end else if (cmd_wr && cmd_code[7:4] == `OP_ENABLE && !en_block) begin
      // a refused enable leaves the flags as they were
      sync_en_r <= sync_en_r | sel;
    end else if (cmd_wr && cmd_code[7:4] == `OP_DISABLE) begin
      // disabling is never refused
      sync_en_r <= sync_en_r & ~sel;
    end
  end
  // activation from command or hardware factor, gated by enable
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_fire <= 4'h0;
    end else begin
      // a trigger on a disabled set is dropped, not kept for later
      sync_fire <= sync_en_r & (sync_trigger |
        ((cmd_wr && cmd_code[7:4] == `OP_ACTIVATE) ? sel : 4'h0));
    end
  end

  // ---------------------------------------------------------------
  // interpolation interrupt and single step
  // ---------------------------------------------------------------
  // a same-cycle event wins over the clear command; the interrupt stays asserted
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      interp_irq_out_n <= 1'b1;
      interp_step <= 1'b0;
    end else begin
      // one step pulse per write; the host spaces the writes
      interp_step <= is_cmd(`CMD_INTERP);
      // a new event in the clear cycle keeps the interrupt asserted
      if (interp_event) begin
        interp_irq_out_n <= 1'b0;
      end else if (is_cmd(`CMD_INTERP)) begin
        interp_irq_out_n <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // speed step
  // ---------------------------------------------------------------
  logic [SPEED_W-1:0] cur_speed_r; // current drive speed
  logic spd_ok; // speed change allowed for addressed axes
  // at least one addressed axis must be driving
  assign spd_ok = !(|(cmd_axes & axis_in.interp)) &&
    !(|(cmd_axes & axis_in.scurve & ~axis_in.steady)) &&
    (|(cmd_axes & axis_in.driving));
  // the stored setting is only copied at idle, steps never touch it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cur_speed_r <= '0;
    end else if (!(|axis_in.driving)) begin
      // with every axis idle the speed picks up the setting for the next drive
      cur_speed_r <= drive_speed_setting_r;
    end else if (is_cmd(`CMD_SPD_UP) && spd_ok) begin
      // no saturation: the host keeps the step within range
      cur_speed_r <= cur_speed_r + speed_step_value_r;
    end else if (is_cmd(`CMD_SPD_DN) && spd_ok) begin
      cur_speed_r <= cur_speed_r - speed_step_value_r;
    end
  end

  // ---------------------------------------------------------------
  // deviation clear pulse
  // ---------------------------------------------------------------
  logic [7:0] dcc_cnt_r; // remaining pulse width
  logic [3:0] dcc_axes_r; // axes being pulsed
  // a clear written during a running pulse is ignored
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dcc_cnt_r <= 8'h00;
      dcc_axes_r <= 4'h0;
    end else if (is_cmd(`CMD_DEVCLR) && dcc_cnt_r == 8'h00) begin
      // a zero width still gives a one-cycle pulse
      dcc_cnt_r <= (home2_r[15:8] == 8'h00) ? 8'h01 : home2_r[15:8];
      dcc_axes_r <= cmd_axes;
    end else if (dcc_cnt_r != 8'h00) begin
      dcc_cnt_r <= dcc_cnt_r - 8'h01;
    end
  end
  // active level comes from bit 0 of the home setting
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      deviation_clear_out <= `DCC_IDLE_RESET; // inactive level while home setting is clear
    end else begin
      deviation_clear_out <= {4{~home2_r[0]}} ^
        ((dcc_cnt_r != 8'h00) ? dcc_axes_r : 4'h0);
    end
  end

  // ---------------------------------------------------------------
  // timer
  // ---------------------------------------------------------------
  logic [TIMER_W-1:0] timer_current_count_r; // count
  logic timer_run_r; // timer running
  logic t_hit; // count reached limit
  assign t_hit = timer_run_r && timer_current_count_r == timer_limit_r;
  // stop wins over start, start over expiry, in one cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      timer_current_count_r <= '0;
      timer_run_r <= 1'b0;
      timer_up <= 1'b0;
    end else begin
      timer_up <= t_hit;
      if (is_cmd(`CMD_TSTOP)) begin
        timer_run_r <= 1'b0;
        timer_current_count_r <= '0;
      end else if (is_cmd(`CMD_TSTART)) begin
        timer_run_r <= 1'b1;
        timer_current_count_r <= '0;
      end else if (t_hit) begin
        // a single shot halts here, a repeating one counts on
        timer_run_r <= mode3_r[`BIT_TREPEAT];
        timer_current_count_r <= '0;
      end else if (timer_run_r) begin
        timer_current_count_r <= timer_current_count_r + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // split pulse
  // ---------------------------------------------------------------
  logic split_on_r; // split active status
  split_state_type sp_st_r; // pulse phase
  logic [7:0] sp_cnt_r; // phase counter
  logic [3:0] sp_axes_r; // axes emitting split pulses
  // start and stop only move the status bit and the axis set
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      split_on_r <= 1'b0;
      sp_axes_r <= 4'h0;
    end else if (is_cmd(`CMD_SPSTART)) begin
      split_on_r <= 1'b1;
      sp_axes_r <= cmd_axes;
    end else if (is_cmd(`CMD_SPSTOP)) begin
      split_on_r <= 1'b0;
    end
  end
  // a high phase always runs to its full width even after a stop
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sp_st_r <= split_idle;
      sp_cnt_r <= 8'h00;
    end else begin
      unique case (sp_st_r)
        split_idle: begin
          // a pulse only starts while a chosen axis drives; a started one runs on
          if (split_on_r && |(sp_axes_r & axis_in.driving)) begin
            sp_st_r <= split_high;
            sp_cnt_r <= split_cfg_r[7:0];
          end
        end
        split_high: begin
          if (sp_cnt_r <= 8'h01) begin
            sp_st_r <= split_low;
            sp_cnt_r <= split_cfg_r[15:8];
          end else begin
            sp_cnt_r <= sp_cnt_r - 8'h01;
          end
        end
        split_low: begin
          // a stop cuts the low phase short
          if (!split_on_r) begin
            sp_st_r <= split_idle;
          end else if (sp_cnt_r <= 8'h01) begin
            sp_st_r <= split_idle;
          end else begin
            sp_cnt_r <= sp_cnt_r - 8'h01;
          end
        end
        default: sp_st_r <= split_idle;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      segment_pulse_out <= 4'h0;
    end else begin
      // output lags the phase by one cycle
      segment_pulse_out <= (sp_st_r == split_high) ? sp_axes_r : 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // drive start hold
  // ---------------------------------------------------------------
  logic [3:0] held_r; // axes in hold
  logic drive_cmd; // any drive command code
  assign drive_cmd = cmd_wr && (cmd_code[7:4] == 4'h5 || cmd_code[7:4] == 4'h6) &&
    cmd_code != `CMD_INTERP;
  // held axes swallow the drive start until the release
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      held_r <= 4'h0;
      drive_go <= 4'h0;
    end else if (is_cmd(`CMD_HOLD)) begin
      held_r <= held_r | cmd_axes;
      drive_go <= 4'h0;
    end else if (is_cmd(`CMD_RELEASE)) begin
      held_r <= 4'h0;
      drive_go <= held_r;
    end else begin
      // axes not in hold start at once
      drive_go <= drive_cmd ? (cmd_axes & ~held_r) : 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // paged state and read port
  // ---------------------------------------------------------------
  logic page_r; // selected page
  // reset shows page 0
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      page_r <= 1'b0;
    end else if (is_cmd(`CMD_PAGE0)) begin
      page_r <= 1'b0;
    end else if (is_cmd(`CMD_PAGE1)) begin
      page_r <= 1'b1;
    end
  end
  // read data appear the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (srst || !bus_req.rd) begin
      rdata <= 16'h0000;
    end else begin
      unique case (bus_req.addr)
        `ADDR_MODE3: rdata <= mode3_r;
        `ADDR_OTHER: rdata <= other_r;
        `ADDR_HOME2: rdata <= home2_r;
        `ADDR_TLIMIT: rdata <= 16'(timer_limit_r);
        `ADDR_STEP: rdata <= 16'(speed_step_value_r);
        `ADDR_DSPEED: rdata <= 16'(drive_speed_setting_r);
        `ADDR_SPLIT: rdata <= split_cfg_r;
        // status words are built from live flags on each read
        `ADDR_MAIN: rdata <= {8'h00, axis_err_r, axis_in.driving};
        `ADDR_FAULT: rdata <= {8'h00, finish_r, axis_err_r};
        `ADDR_PAGED: rdata <= page_r ?
          {1'b1, 7'h00, 1'b0, split_on_r, |(axis_in.steady), 1'b0, sync_en_r} :
          {1'b0, 11'h000, held_r};
        `ADDR_TCOUNT: rdata <= 16'(timer_current_count_r);
        `ADDR_CURSPD: rdata <= 16'(cur_speed_r);
        default: rdata <= 16'h0000;
      endcase
    end
  end

endmodule // motion_aux_command_decoder

// ===== src/motion_aux_pkg.sv
// types for the auxiliary command decoder
package motion_aux_pkg;
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;
  // per-axis drive condition inputs
  typedef struct packed {
    logic [3:0] driving;
    logic [3:0] scurve;
    logic [3:0] steady;
    logic [3:0] interp;
    logic [3:0] err_set;
    logic [3:0] finish_set;
  } axis_in_type;
  typedef enum logic [1:0] {
    split_idle = 2'b00,
    split_high = 2'b01,
    split_low = 2'b10
  } split_state_type;
endpackage
